// *** logic/clock_mode_and_reset_sequencer.v ***
// Functional notes
// - Reset leaves the unit in internal-reference synthesizer mode.
// - Default setup: VCO 50 MHz, post divider 0x03, bus 6.25 MHz.
// - Internal-reference mode: watchdog/tick clocks only internal ref or aux RC.
// - External-reference mode: bus from synthesizer, reference from oscillator.
// - Losing lock also clears oscillator-up status.
// - Oscillator-up lost: synthesizer clock is VCO divided by four.
// - Bypass mode: oscillator-up lost sets synth select automatically.
// - Watchdog resume delayed after stop when on aux RC with disable bit.
// - All reset sources share one reset vector.
// - Only oscillator monitor and watchdog resets carry local enables.
// - Any reset source drives reset pin low for 512 synth cycles.
// - Internal reset holds until a 768-cycle sequence completes.
// - Reset pin held low externally keeps internal reset asserted.
// - During system reset the synthesizer runs at its reset frequency.
// - Oscillator monitor reset on oscillator failure when both enables set.
// - Synthesizer monitor reset on synthesizer clock failure.
// - Full stop disables oscillator, synthesizer and both monitors.
// - Synthesizer-selected bus clock is half the synthesizer clock.
`timescale 1ns/10ps
`default_nettype none
`include "clock_sequencer_consts.vh"

module clock_mode_and_reset_sequencer
(
  input  wire       CLK,
  input  wire       RESET_N,
  input  wire [3:0] ADDR,
  input  wire [7:0] WDATA,
  input  wire       WR,
  input  wire       RD,
  output reg  [7:0] RDATA,
  input  wire       SYNTH_LOCK,
  input  wire       OSC_RUNNING,
  input  wire       OSC_MON_FAIL,
  input  wire       SYNTH_MON_FAIL,
  input  wire       POWER_ON_RST,
  input  wire       LOW_VOLTAGE_RST,
  input  wire       WATCHDOG_TIMEOUT,
  input  wire       FULL_STOP,
  input  wire       STOP_EXIT,
  input  wire       RESET_PIN_IN,
  output reg        RESET_PIN_OUT,
  output reg        RESET_PIN_OE,
  output reg        SYS_RESET,
  output reg        RESET_VECTOR_REQ,
  output reg        SYNTH_SELECT,
  output reg        OSC_ENABLE,
  output reg        SYNTH_ENABLE,
  output reg        MONITORS_ENABLE,
  output reg        SYNTH_REF_OSC,
  output reg        SYNTH_RESET_FREQ,
  output reg  [4:0] POST_DIVIDER,
  output reg  [7:0] VCO_SETTING,
  output reg        BUS_DIV_TWO,
  output reg  [1:0] WATCHDOG_SRC,
  output reg  [1:0] TICK_SRC,
  output reg        WATCHDOG_RUN
);

  ////////////////////////////////////////////////////////////////////////////
  // Synchronisers for pins and analog status.

  reg [7:0] sync_a;
  reg [7:0] sync_b;

  always @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      sync_a <= 8'hFF;
      sync_b <= 8'hFF;
    end
    else
    begin
      sync_a <= {RESET_PIN_IN, ~SYNTH_LOCK, ~OSC_RUNNING, ~OSC_MON_FAIL,
                 ~SYNTH_MON_FAIL, ~POWER_ON_RST, ~LOW_VOLTAGE_RST,
                 ~STOP_EXIT};
      sync_b <= sync_a;
    end
  end

  wire pin_high    = sync_b[7];
  wire lock        = ~sync_b[6];
  wire osc_running = ~sync_b[5];
  wire osc_fail    = ~sync_b[4];
  wire synth_fail  = ~sync_b[3];
  wire por         = ~sync_b[2];
  wire low_voltage_reset         = ~sync_b[1];
  wire stop_exit   = ~sync_b[0];

  ////////////////////////////////////////////////////////////////////////////
  // Software registers.

  reg [7:0] ctrl;
  reg       osc_monitor_reset_enable;
  reg [6:0] wdog;
  reg [7:0] synth_cfg;
  reg       osc_up_status;
  reg       full_stop;

  wire osc_enable    = ctrl[`CTRL_OSC_EN];
  wire synth_select  = ctrl[`CTRL_SYNTH_SEL];
  wire bypass_mode   = osc_enable & ~synth_select;
  wire ext_ref_mode  = osc_enable & synth_select;
  wire [1:0] wd_req  = wdog[`WDOG_SRC_HI:`WDOG_SRC_LO];
  wire [1:0] tk_req  = wdog[`TICK_SRC_HI:`TICK_SRC_LO];
  wire [2:0] mode    = bypass_mode ? `MODE_BYPASS :
                       ext_ref_mode ? `MODE_EXT_REF : `MODE_INT_REF;

  always @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      ctrl                     <= `CTRL_RESET_VAL;
      osc_monitor_reset_enable <= 1'b0;
      wdog                     <= 7'h00;
      synth_cfg                <= `VCO_DEFAULT_MHZ;
      osc_up_status            <= 1'b0;
      full_stop                <= 1'b0;
    end
    else if (SYS_RESET)
    begin
      // Internal reset returns the unit to its default mode.
      ctrl                     <= `CTRL_RESET_VAL;
      osc_monitor_reset_enable <= 1'b0;
      wdog                     <= 7'h00;
      synth_cfg                <= `VCO_DEFAULT_MHZ;
      osc_up_status            <= 1'b0;
      full_stop                <= 1'b0;
    end
    else
    begin
      full_stop <= FULL_STOP;
      // Oscillator-up follows lock and is lost with it.
      osc_up_status <= osc_enable & lock & osc_running & ~FULL_STOP;
      if (WR && ADDR == `ADDR_CTRL)
        ctrl <= WDATA;
      if (WR && ADDR == `ADDR_OSC_CFG && !osc_enable)
        osc_monitor_reset_enable <= WDATA[`OSC_MON_RST_EN];
      if (WR && ADDR == `ADDR_WDOG)
        wdog <= WDATA[6:0];
      if (WR && ADDR == `ADDR_SYNTH)
        synth_cfg <= WDATA;
      // Hardware set of the select bit wins over a software clear.
      if (bypass_mode && osc_up_status && !(osc_enable & lock & osc_running))
        ctrl[`CTRL_SYNTH_SEL] <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Reset generator.

  reg [9:0] rst_count;
  reg       rst_active;
  reg       oe_d1;
  reg       oe_d2;
  wire      wd_enabled = |wdog[`WDOG_TO_HI:`WDOG_TO_LO];
  wire      osc_mon_rst = osc_enable & osc_monitor_reset_enable & osc_fail &
                          ~full_stop;
  wire      synth_mon_rst = synth_fail & ~full_stop;
  // Our own drive reads back low through the synchroniser for two cycles
  // after it ends; those cycles are masked so that the generator does not
  // take its own release for an external reset. The mask assumes the pin
  // rises within one cycle of release; a slower pull-up needs a longer one.
  wire      pin_low_ext = ~pin_high & ~RESET_PIN_OE & ~oe_d1 & ~oe_d2;
  wire      source = por | low_voltage_reset | synth_mon_rst | osc_mon_rst |
                     (wd_enabled & WATCHDOG_TIMEOUT) |
                     pin_low_ext;

  always @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      rst_count        <= 10'd0;
      rst_active       <= 1'b1;
      RESET_PIN_OUT    <= 1'b0;
      RESET_PIN_OE     <= 1'b1;
      SYS_RESET        <= 1'b1;
      RESET_VECTOR_REQ <= 1'b0;
      oe_d1            <= 1'b1;
      oe_d2            <= 1'b1;
    end
    else
    begin
      RESET_VECTOR_REQ <= 1'b0;
      RESET_PIN_OUT    <= 1'b0;
      oe_d1            <= RESET_PIN_OE;
      oe_d2            <= oe_d1;
      if (source && (!rst_active || rst_count >= `RESET_PIN_CYCLES))
      begin
        rst_count  <= 10'd0;
        rst_active <= 1'b1;
      end
      else if (rst_active)
      begin
        if (rst_count == `RESET_SEQ_CYCLES - 10'd1)
        begin
          // External low pin keeps reset on beyond the sequence.
          if (pin_high)
            rst_active <= 1'b0;
        end
        else
          rst_count <= rst_count + 10'd1;
      end
      // One cycle of drive for each count value below the pin length.
      RESET_PIN_OE <= rst_active && rst_count < `RESET_PIN_CYCLES &&
                      !(source && rst_count >= `RESET_PIN_CYCLES);
      SYS_RESET <= rst_active;
      if (SYS_RESET && !rst_active)
        RESET_VECTOR_REQ <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Clock steering outputs and watchdog resume latency.

  reg [2:0] wd_sync;
  reg       stop_seen;

  always @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      SYNTH_SELECT     <= 1'b1;
      OSC_ENABLE       <= 1'b0;
      SYNTH_ENABLE     <= 1'b1;
      MONITORS_ENABLE  <= 1'b1;
      SYNTH_REF_OSC    <= 1'b0;
      SYNTH_RESET_FREQ <= 1'b1;
      POST_DIVIDER     <= `POST_DIV_DEFAULT;
      VCO_SETTING      <= `VCO_DEFAULT_MHZ;
      BUS_DIV_TWO      <= 1'b1;
      WATCHDOG_SRC     <= `SRC_INT_REF;
      TICK_SRC         <= `SRC_INT_REF;
      WATCHDOG_RUN     <= 1'b0;
      wd_sync          <= 3'd0;
      stop_seen        <= 1'b0;
      RDATA            <= 8'h00;
    end
    else
    begin
      SYNTH_SELECT     <= synth_select;
      OSC_ENABLE       <= osc_enable & ~full_stop;
      SYNTH_ENABLE     <= ~full_stop;
      MONITORS_ENABLE  <= ~full_stop;
      SYNTH_REF_OSC    <= osc_enable;
      SYNTH_RESET_FREQ <= SYS_RESET;
      // Without oscillator-up in an oscillator mode, divide VCO by four.
      POST_DIVIDER     <= (osc_enable && !osc_up_status) || !lock ?
                          `POST_DIV_UNLOCK : `POST_DIV_DEFAULT;
      VCO_SETTING      <= synth_cfg;
      BUS_DIV_TWO      <= synth_select;
      // The oscillator is offered only when it is enabled.
      WATCHDOG_SRC     <= (wd_req == `SRC_OSC && !osc_enable) ?
                          `SRC_INT_REF : wd_req;
      TICK_SRC         <= (tk_req == `SRC_OSC && !osc_enable) ?
                          `SRC_INT_REF : tk_req;
      if (full_stop)
        stop_seen <= 1'b1;
      if (full_stop)
        WATCHDOG_RUN <= 1'b0;
      else if (stop_seen && wd_req == `SRC_AUX_RC && ctrl[`CTRL_STOP_AUX])
      begin
        // Aux clock was gated in stop; wait for resynchronisation.
        if (stop_exit || wd_sync != 3'd0)
          wd_sync <= wd_sync + 3'd1;
        if (wd_sync == `WDOG_SYNC_CYCLES - 3'd1)
        begin
          WATCHDOG_RUN <= wd_enabled;
          stop_seen    <= 1'b0;
          wd_sync      <= 3'd0;
        end
      end
      else
      begin
        stop_seen    <= 1'b0;
        WATCHDOG_RUN <= wd_enabled & ~SYS_RESET;
      end
      RDATA <= 8'h00;
      if (RD)
      begin
        case (ADDR)
          `ADDR_CTRL:    RDATA <= ctrl;
          `ADDR_OSC_CFG: RDATA <= {7'h00, osc_monitor_reset_enable};
          `ADDR_WDOG:    RDATA <= {1'b0, wdog};
          `ADDR_STATUS:  RDATA <= {3'h0, mode, osc_up_status, lock};
          `ADDR_SYNTH:   RDATA <= synth_cfg;
          default:       RDATA <= 8'h00;
        endcase
      end
    end
  end

endmodule // clock_mode_and_reset_sequencer
`default_nettype wire

// *** logic/clock_sequencer_consts.vh ***
`ifndef CLOCK_SEQUENCER_CONSTS_VH
`define CLOCK_SEQUENCER_CONSTS_VH

// Register offsets on the plain register port.
`define ADDR_CTRL        4'h0
`define ADDR_OSC_CFG     4'h1
`define ADDR_WDOG        4'h2
`define ADDR_STATUS      4'h3
`define ADDR_SYNTH       4'h4

// Control register fields.
`define CTRL_SYNTH_SEL   0
`define CTRL_OSC_EN      1
`define CTRL_LOCK_IE     2
`define CTRL_OSC_IE      3
`define CTRL_STOP_AUX    4
`define CTRL_RESET_VAL   8'h01

// Oscillator configuration fields.
`define OSC_MON_RST_EN   0

// Watchdog control fields.
`define WDOG_TO_HI       2
`define WDOG_TO_LO       0
`define WDOG_SRC_HI      4
`define WDOG_SRC_LO      3
`define TICK_SRC_HI      6
`define TICK_SRC_LO      5

// Clock source codes for watchdog and periodic tick.
`define SRC_INT_REF      2'h0
`define SRC_AUX_RC       2'h1
`define SRC_OSC          2'h2

// Status fields.
`define ST_LOCK          0
`define ST_OSC_UP        1
`define ST_MODE_LO       2
`define ST_MODE_HI       4

// Default synthesizer setup: VCO 50 MHz, post divider 0x03.
`define VCO_DEFAULT_MHZ  8'h32
`define POST_DIV_DEFAULT 5'h03
`define POST_DIV_UNLOCK  5'h03

// Mode codes reported in status.
`define MODE_INT_REF     3'h1
`define MODE_EXT_REF     3'h2
`define MODE_BYPASS      3'h4

// Reset sequence lengths and watchdog resume delay in synthesizer clock cycles.
`define RESET_PIN_CYCLES 10'd512
`define RESET_SEQ_CYCLES 10'd768
`define WDOG_SYNC_CYCLES 3'd4

`endif

// *** testbench/clock_sequencer_props.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "clock_sequencer_consts.vh"
module clock_sequencer_props
(
  input wire logic       CLK,
  input wire logic       RESET_N,
  input wire logic       RESET_PIN_OE,
  input wire logic       SYS_RESET,
  input wire logic       RESET_VECTOR_REQ,
  input wire logic       SYNTH_RESET_FREQ,
  input wire logic       FULL_STOP,
  input wire logic       OSC_ENABLE,
  input wire logic       SYNTH_ENABLE,
  input wire logic       MONITORS_ENABLE,
  input wire logic       SYNTH_SELECT,
  input wire logic       SYNTH_LOCK,
  input wire logic       OSC_RUNNING,
  input wire logic       BUS_DIV_TWO,
  input wire logic [1:0] WATCHDOG_SRC,
  input wire logic [1:0] TICK_SRC
);
  logic [10:0] oe_cnt;
  logic [10:0] sr_cnt;
  logic        seen;

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESET_N);

  ////////////////////////////////////////////////////////////////////////////
  // The run that follows reset release is skipped, since its start is hidden.
  always @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      oe_cnt <= 11'h0;
      sr_cnt <= 11'h0;
      seen   <= 1'b0;
    end
    else
    begin
      oe_cnt <= RESET_PIN_OE ? oe_cnt + 11'h1 : 11'h0;
      sr_cnt <= SYS_RESET ? sr_cnt + 11'h1 : 11'h0;
      seen   <= seen | (!SYS_RESET && sr_cnt != 11'h0);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  AST_PIN_LEN: assert property (
    $fell(RESET_PIN_OE) && seen |-> oe_cnt == 11'h200)
    else $error("Reset pin drive length wrong.");
  AST_SEQ_LEN: assert property (
    $fell(SYS_RESET) && seen |-> sr_cnt >= 11'h300)
    else $error("Internal reset released early.");
  AST_VECTOR: assert property (
    $fell(SYS_RESET) |-> ##[0:1] RESET_VECTOR_REQ)
    else $error("No vector request at reset release.");
  AST_RST_FREQ: assert property (
    SYS_RESET [*2] |-> SYNTH_RESET_FREQ)
    else $error("Synthesizer not at reset frequency.");
  AST_FULL_STOP: assert property (
    FULL_STOP [*3] |-> !(OSC_ENABLE || SYNTH_ENABLE || MONITORS_ENABLE))
    else $error("Clocks left running in full stop.");
  AST_FALLBACK: assert property (
    !SYNTH_SELECT && !(OSC_RUNNING && SYNTH_LOCK) |-> ##[1:6] SYNTH_SELECT)
    else $error("Bypass did not fall back to synthesizer.");
  AST_BUS_HALF: assert property (
    SYNTH_SELECT [*2] |-> BUS_DIV_TWO)
    else $error("Bus clock not halved on synthesizer.");
  AST_INT_SRC: assert property (
    (!OSC_ENABLE && !FULL_STOP) [*3] |->
      WATCHDOG_SRC != `SRC_OSC && TICK_SRC != `SRC_OSC)
    else $error("Oscillator source chosen while it is off.");

  cover property ($fell(RESET_PIN_OE) && seen);
  cover property (!SYNTH_SELECT ##1 SYNTH_SELECT);
  cover property (FULL_STOP [*2]);
endmodule // clock_sequencer_props

bind clock_mode_and_reset_sequencer clock_sequencer_props u_props
(
  .CLK, .RESET_N, .RESET_PIN_OE, .SYS_RESET, .RESET_VECTOR_REQ,
  .SYNTH_RESET_FREQ, .FULL_STOP, .OSC_ENABLE, .SYNTH_ENABLE,
  .MONITORS_ENABLE, .SYNTH_SELECT, .SYNTH_LOCK, .OSC_RUNNING,
  .BUS_DIV_TWO, .WATCHDOG_SRC, .TICK_SRC
);
`default_nettype wire

// *** testbench/clock_mode_and_reset_sequencer_tb.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "clock_sequencer_consts.vh"
module clock_mode_and_reset_sequencer_tb;
  logic       CLK, RESET_N, WR, RD, SYNTH_LOCK, OSC_RUNNING;
  logic       FULL_STOP, STOP_EXIT, ext_pin;
  logic [3:0] ADDR;
  logic [7:0] WDATA;
  logic [4:0] src;
  wire  [7:0] RDATA, VCO_SETTING;
  wire  [4:0] POST_DIVIDER;
  wire  [1:0] WATCHDOG_SRC, TICK_SRC;
  wire        RESET_PIN_OUT, RESET_PIN_OE, SYS_RESET, RESET_VECTOR_REQ;
  wire        SYNTH_SELECT, OSC_ENABLE, SYNTH_ENABLE, MONITORS_ENABLE;
  wire        SYNTH_REF_OSC, SYNTH_RESET_FREQ, BUS_DIV_TWO, WATCHDOG_RUN;
  wire        pin = RESET_PIN_OE ? RESET_PIN_OUT : ext_pin;
  int         fail_count, n_checks, cyc;

  clock_mode_and_reset_sequencer u_clock_mode_and_reset_sequencer
  (
    .CLK, .RESET_N, .ADDR, .WDATA, .WR, .RD, .RDATA, .SYNTH_LOCK,
    .OSC_RUNNING, .OSC_MON_FAIL(src[3]), .SYNTH_MON_FAIL(src[2]),
    .POWER_ON_RST(src[0]), .LOW_VOLTAGE_RST(src[1]),
    .WATCHDOG_TIMEOUT(src[4]), .FULL_STOP, .STOP_EXIT,
    .RESET_PIN_IN(pin), .RESET_PIN_OUT, .RESET_PIN_OE, .SYS_RESET,
    .RESET_VECTOR_REQ, .SYNTH_SELECT, .OSC_ENABLE, .SYNTH_ENABLE,
    .MONITORS_ENABLE, .SYNTH_REF_OSC, .SYNTH_RESET_FREQ, .POST_DIVIDER,
    .VCO_SETTING, .BUS_DIV_TWO, .WATCHDOG_SRC, .TICK_SRC, .WATCHDOG_RUN
  );

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [10:0] got, input logic [10:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("ERROR at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge CLK);
    ADDR <= a;
    WDATA <= d;
    WR <= 1'b1;
    @(posedge CLK);
    WR <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge CLK);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge CLK);
    RD <= 1'b0;
    #1;
    chk(RDATA, e);
  endtask

  task automatic wait_rst();
    for (int k = 0; k < 1500 && SYS_RESET !== 1'b0; k++)
    begin
      @(posedge CLK);
      #1;
    end
    chk(SYS_RESET, 1'b0);
  endtask

  task automatic do_reset();
    RESET_N <= 1'b0;
    repeat (10) @(posedge CLK);
    RESET_N <= 1'b1;
    wait_rst();
  endtask

  // Pulses stay short so that the drive starts after the caller returns.
  task automatic pulse(input int b);
    repeat ($urandom % 4) @(posedge CLK);
    src[b] <= 1'b1;
    repeat (1 + $urandom % 2) @(posedge CLK);
    src[b] <= 1'b0;
  endtask

  task automatic seq();
    logic [10:0] oe;
    logic [10:0] sr;
    oe = 11'h0;
    sr = 11'h0;
    #1;
    for (int k = 0; k < 40 && RESET_PIN_OE !== 1'b1; k++)
    begin
      @(posedge CLK);
      #1;
    end
    while (SYS_RESET === 1'b1 && sr < 11'h7FF)
    begin
      oe += RESET_PIN_OE;
      sr++;
      @(posedge CLK);
      #1;
    end
    chk(oe, 11'h200);
    chk(sr, 11'h300);
  endtask

  task automatic done(input string s);
    $display("test %s done", s);
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    CLK = 1'b0;
    forever #25 CLK = ~CLK;
  end

  always @(posedge CLK)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      fail_count++;
      tally_and_finish();
    end
  end

  initial
  begin
    {RESET_N, WR, RD, OSC_RUNNING, FULL_STOP, STOP_EXIT} = 6'h00;
    {SYNTH_LOCK, ext_pin, src, ADDR, WDATA} = 19'h60000;
    void'($urandom(92899));
    do_reset();
    rd(`ADDR_STATUS, 8'h05);
    rd(`ADDR_CTRL, `CTRL_RESET_VAL);
    rd(`ADDR_SYNTH, `VCO_DEFAULT_MHZ);
    rd(4'hF, 8'h00);
    chk(POST_DIVIDER, `POST_DIV_DEFAULT);
    chk(BUS_DIV_TWO, 1'b1);
    chk(VCO_SETTING, `VCO_DEFAULT_MHZ);
    wr(`ADDR_WDOG, 8'h50);
    rd(`ADDR_STATUS, 8'h05);
    chk({WATCHDOG_SRC, TICK_SRC}, 11'h0);
    done("default mode");
    wr(`ADDR_OSC_CFG, 8'h01);
    wr(`ADDR_CTRL, 8'h03);
    OSC_RUNNING <= 1'b1;
    repeat (8) @(posedge CLK);
    rd(`ADDR_STATUS, 8'h0B);
    chk(SYNTH_REF_OSC, 1'b1);
    wr(`ADDR_WDOG, 8'h50);
    wr(`ADDR_OSC_CFG, 8'h00);
    rd(`ADDR_OSC_CFG, 8'h01);
    chk({WATCHDOG_SRC, TICK_SRC}, 11'h0A);
    SYNTH_LOCK <= 1'b0;
    repeat (6) @(posedge CLK);
    rd(`ADDR_STATUS, 8'h08);
    chk(POST_DIVIDER, `POST_DIV_UNLOCK);
    SYNTH_LOCK <= 1'b1;
    repeat (8) @(posedge CLK);
    done("external reference");
    wr(`ADDR_CTRL, 8'h02);
    rd(`ADDR_STATUS, 8'h13);
    chk(BUS_DIV_TWO, 1'b0);
    OSC_RUNNING <= 1'b0;
    repeat (6) @(posedge CLK);
    rd(`ADDR_CTRL, 8'h03);
    OSC_RUNNING <= 1'b1;
    done("bypass");
    wr(`ADDR_WDOG, 8'h09);
    wr(`ADDR_CTRL, 8'h13);
    #1;
    chk(WATCHDOG_RUN, 1'b1);
    FULL_STOP <= 1'b1;
    repeat (3) @(posedge CLK);
    #1;
    chk({OSC_ENABLE, SYNTH_ENABLE, MONITORS_ENABLE}, 11'h0);
    chk(WATCHDOG_RUN, 1'b0);
    FULL_STOP <= 1'b0;
    STOP_EXIT <= 1'b1;
    @(posedge CLK);
    STOP_EXIT <= 1'b0;
    repeat (3) @(posedge CLK);
    #1;
    chk(WATCHDOG_RUN, 1'b0);
    repeat (3) @(posedge CLK);
    #1;
    chk(WATCHDOG_RUN, 1'b1);
    done("full stop");
    do_reset();
    for (int b = 0; b < 5; b++)
      for (int e = 0; e < 2; e++)
      begin
        if (e)
        begin
          wr(`ADDR_OSC_CFG, 8'h01);
          wr(`ADDR_CTRL, 8'h03);
          wr(`ADDR_WDOG, 8'h07);
        end
        pulse(b);
        if (e || b < 3)
          seq();
        else
        begin
          repeat (8) @(posedge CLK);
          chk(SYS_RESET, 1'b0);
        end
      end
    done("reset sources");
    pulse(0);
    repeat (600) @(posedge CLK);
    pulse(1);
    seq();
    done("late source");
    ext_pin <= 1'b0;
    repeat (1200) @(posedge CLK);
    chk(SYS_RESET, 1'b1);
    ext_pin <= 1'b1;
    wait_rst();
    done("external pin");
    tally_and_finish();
  end
endmodule // clock_mode_and_reset_sequencer_tb
`default_nettype wire
